// ### hw/adcs_ctrl.sv
// Converter control sequencer: registers, conversion sequencing and sleep handling
//
// Operation
// [RQ1] Justify bit set gives right-justified result, clear gives left-justified.
// [RQ2] Negative reference bit picks external pin when set, ground when clear.
// [RQ3] Positive reference bit picks external pin when set, supply when clear.
// [RQ4] Channel field connects analog input equal to its value to sample-hold.
// [RQ5] Writing go starts conversion; go reads one while running, hardware clears.
// [RQ6] Enable set powers converter; clear shuts it down.
// [RQ7] Clock field selects Fosc divide 2..64 or internal RC oscillator.
// [RQ8] RC conversion clock comes from dedicated oscillator at most 500 kHz.
// [RQ9] Clock register bit 7 and bits 3..0 always read zero.
// [RQ10] Software waits for acquisition before setting go.
// [RQ11] Software makes every analog channel pin an input.
// [RQ12] Software configures pins, references, channel, clock, enable, interrupts, then starts.
// [RQ13] Software clears done flag, sets interrupt enables before using interrupt.
// [RQ14] Software polls go or waits interrupt, then reads result.
// [RQ15] Two bit periods pass after conversion before next acquisition.
// [RQ16] Conversion in sleep works only with RC clock selected.
// [RQ17] With RC clock, start is delayed one instruction cycle after go.
// [RQ18] Sleep conversion completion clears go and loads result.
// [RQ19] Enabled interrupt wakes device; vector only if global enable set.
// [RQ20] Sleep completion without interrupt enabled powers converter down, enable stays.
// [RQ21] Sleep with non-RC clock aborts conversion, powers down, enable stays.
// [RQ22] Completion clears go, sets done flag, raises interrupt if enabled.
// [RQ23] Software clearing go aborts conversion; result keeps previous value.
// [RQ24] After abort, wait two bit periods then acquire selected channel.
// [RQ25] Right mode puts two top bits low in high byte; left mode mirrored.
// [RQ26] Go stays zero and starts are ignored while enable is zero.
`timescale 1ns/10ps
`include "adcs_defines.svh"

module adcs_ctrl #(
    parameter int FRC_CYCLES = `ADCS_FRC_CYCLES
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    // Register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    // Core interface
    input  wire logic          sleep_active,
    input  wire logic          global_irq_enable,
    input  wire logic          peripheral_irq_enable,
    output logic               conv_irq,
    output logic               wake_req,
    output logic               wake_vector,
    // Analog front end
    input  wire logic          cmp_in,
    output logic               adc_power_on,
    output logic               sample_connect,
    output logic      [2:0]    channel_sel,
    output logic               neg_ref_ext,
    output logic               pos_ref_ext,
    output logic      [9:0]    dac_code
);

    localparam int INSTR_LAST = `ADCS_INSTR_CYCLES - 1;
    localparam int CONV_LAST  = `ADCS_CONV_TADS - 1;
    localparam int HOLD_LAST  = `ADCS_HOLD_TADS - 1;

    typedef struct packed {
        logic [7:0]           ctrl;
        logic [2:0]           clkcfg;
        logic                 done;
        logic                 irq_en;
        logic [9:0]           result;
        logic [9:0]           sar;
        adcs_pkg::adcs_state_t state;
        logic [3:0]           tadn;
        logic [2:0]           dly;
        logic                 pd;
        logic                 cmp_m;
        logic                 cmp_s;
        logic [7:0]           rdata;
        logic                 irq;
        logic                 wake;
        logic                 wakev;
        logic                 pwr;
        logic                 acq;
        logic                 div_clr;
    } adcs_st_t;

    adcs_st_t st_ff;
    adcs_st_t nxt_st;
    logic     tad_tick;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == 2'b11);
    endfunction

    function automatic logic [7:0] fmt_result(input logic [9:0] res, input logic right,
                                              input logic hi);
        if (right) begin
            fmt_result = hi ? {6'h00, res[9:8]} : res[7:0];
        end else begin
            fmt_result = hi ? res[9:2] : {res[1:0], 6'h00};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Bit period generator
    // ------------------------------------------------------------------------
    adcs_tad_gen #(
        .FRC_CYCLES (FRC_CYCLES)
    ) u_tad_gen (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .run      (((st_ff.state == adcs_pkg::ADCS_CONV) || (st_ff.state == adcs_pkg::ADCS_HOLD))
                   && !st_ff.div_clr),
        .clk_sel  (st_ff.clkcfg),
        .tad_tick (tad_tick)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic       wr_ctrl;
        logic       busy;
        logic       rc;
        logic       complete;
        logic [3:0] idx;
        logic [9:0] mask;
        logic [9:0] sar_n;
        wr_ctrl  = reg_wr && (reg_addr == `ADCS_OFF_CTRL);
        busy     = (st_ff.state == adcs_pkg::ADCS_CONV) || (st_ff.state == adcs_pkg::ADCS_START_DLY);
        rc       = is_rc(st_ff.clkcfg);
        complete = 1'b0;
        idx      = 4'(`ADCS_CONV_TADS - 1) - st_ff.tadn;
        mask     = 10'h001 << idx;
        sar_n    = st_ff.cmp_s ? st_ff.sar : (st_ff.sar & ~mask);
        if (idx != 4'h0) begin
            sar_n = sar_n | (mask >> 1);
        end
        nxt_st       = st_ff;
        nxt_st.cmp_m = cmp_in;
        nxt_st.cmp_s = st_ff.cmp_m;
        nxt_st.wake  = 1'b0;
        nxt_st.wakev = 1'b0;
        nxt_st.div_clr = 1'b0;

        // Register writes
        if (reg_wr && (reg_addr == `ADCS_OFF_CLKCFG)) begin
            nxt_st.clkcfg = reg_wdata[`ADCS_CKS_HI:`ADCS_CKS_LO];                   // [RQ7]
        end
        if (reg_wr && (reg_addr == `ADCS_OFF_IRQ_EN)) begin
            nxt_st.irq_en = reg_wdata[`ADCS_BIT_IRQ_EN];
        end
        if (reg_wr && (reg_addr == `ADCS_OFF_STATUS)) begin
            nxt_st.done = reg_wdata[`ADCS_BIT_DONE];
        end
        if (wr_ctrl) begin
            nxt_st.ctrl = reg_wdata;
            if (!reg_wdata[`ADCS_BIT_ENABLE]) begin
                nxt_st.ctrl[`ADCS_BIT_GO] = 1'b0;                                    // [RQ26]
            end
        end

        // Sequencer
        case (st_ff.state)
            adcs_pkg::ADCS_ACQ: begin
                if (nxt_st.ctrl[`ADCS_BIT_GO] && !(sleep_active && !rc)) begin      // [RQ5]
                    nxt_st.tadn  = 4'h0;
                    nxt_st.dly   = 3'h0;
                    nxt_st.state = rc ? adcs_pkg::ADCS_START_DLY : adcs_pkg::ADCS_CONV;
                end
            end
            adcs_pkg::ADCS_START_DLY: begin
                nxt_st.dly = st_ff.dly + 3'h1;
                if (st_ff.dly == 3'(INSTR_LAST)) begin
                    nxt_st.state = adcs_pkg::ADCS_CONV;                              // [RQ17]
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (tad_tick) begin
                    nxt_st.tadn = st_ff.tadn + 4'h1;
                    if (st_ff.tadn == 4'h0) begin
                        nxt_st.sar = 10'h200;
                    end else begin
                        nxt_st.sar = sar_n;
                    end
                    if (st_ff.tadn == 4'(CONV_LAST)) begin
                        complete      = 1'b1;
                        nxt_st.result = sar_n;                                       // [RQ18]
                        nxt_st.state  = adcs_pkg::ADCS_HOLD;
                        nxt_st.tadn   = 4'h0;
                    end
                end
            end
            adcs_pkg::ADCS_HOLD: begin
                // A tick left over from an aborted conversion would shorten the wait
                if (tad_tick && !st_ff.div_clr) begin
                    nxt_st.tadn = st_ff.tadn + 4'h1;
                    if (st_ff.tadn == 4'(HOLD_LAST)) begin
                        nxt_st.state = adcs_pkg::ADCS_ACQ;                           // [RQ15] [RQ24]
                    end
                end
            end
            default: begin
                nxt_st.state = adcs_pkg::ADCS_ACQ;
            end
        endcase

        // Software abort, disable, or sleep on a non-RC clock
        if (busy && (!nxt_st.ctrl[`ADCS_BIT_GO] || (sleep_active && !rc))) begin
            complete                  = 1'b0;
            nxt_st.result             = st_ff.result;                                // [RQ23]
            nxt_st.ctrl[`ADCS_BIT_GO] = 1'b0;                                        // [RQ21]
            nxt_st.state              = adcs_pkg::ADCS_HOLD;                         // [RQ24]
            nxt_st.tadn               = 4'h0;
            nxt_st.div_clr            = 1'b1;                                        // [RQ24]
        end

        // Completion
        if (complete) begin
            nxt_st.ctrl[`ADCS_BIT_GO] = 1'b0;                                        // [RQ22]
            nxt_st.done               = 1'b1;                                        // [RQ22]
            if (sleep_active && st_ff.irq_en && peripheral_irq_enable) begin
                nxt_st.wake  = 1'b1;                                                 // [RQ19]
                nxt_st.wakev = global_irq_enable;                                    // [RQ19]
            end else if (sleep_active) begin
                nxt_st.pd = 1'b1;                                                    // [RQ20]
            end
        end

        // Sleep power-down, released when sleep ends
        if (sleep_active && !rc) begin
            nxt_st.pd = 1'b1;                                                        // [RQ21] [RQ16]
        end else if (!sleep_active) begin
            nxt_st.pd = 1'b0;
        end
        nxt_st.pwr = nxt_st.ctrl[`ADCS_BIT_ENABLE] && !nxt_st.pd;                   // [RQ6]
        nxt_st.irq = nxt_st.done && nxt_st.irq_en;                                   // [RQ22]
        nxt_st.acq = (nxt_st.state == adcs_pkg::ADCS_ACQ);

        // Read data, valid the cycle after the strobe
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `ADCS_OFF_CTRL:   nxt_st.rdata = st_ff.ctrl;
                `ADCS_OFF_CLKCFG: nxt_st.rdata = {1'b0, st_ff.clkcfg, 4'h0};          // [RQ9]
                `ADCS_OFF_RES_HI: nxt_st.rdata = fmt_result(st_ff.result,
                                      st_ff.ctrl[`ADCS_BIT_JUSTIFY], 1'b1);          // [RQ1] [RQ25]
                `ADCS_OFF_RES_LO: nxt_st.rdata = fmt_result(st_ff.result,
                                      st_ff.ctrl[`ADCS_BIT_JUSTIFY], 1'b0);          // [RQ1] [RQ25]
                `ADCS_OFF_STATUS: nxt_st.rdata = {1'b0, st_ff.done, 6'h00};
                `ADCS_OFF_IRQ_EN: nxt_st.rdata = {1'b0, st_ff.irq_en, 6'h00};
                default:          nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_ff        <= '0;
            st_ff.ctrl   <= `ADCS_RST_CTRL;
            st_ff.clkcfg <= `ADCS_RST_CLKCFG;
            st_ff.state  <= adcs_pkg::ADCS_ACQ;
            st_ff.acq    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata      = st_ff.rdata;
    assign conv_irq       = st_ff.irq;
    assign wake_req       = st_ff.wake;
    assign wake_vector    = st_ff.wakev;
    assign adc_power_on   = st_ff.pwr;
    assign sample_connect = st_ff.acq;
    assign channel_sel    = st_ff.ctrl[`ADCS_CHS_HI:`ADCS_CHS_LO];                  // [RQ4]
    assign neg_ref_ext    = st_ff.ctrl[`ADCS_BIT_NEG_REF];                          // [RQ2]
    assign pos_ref_ext    = st_ff.ctrl[`ADCS_BIT_POS_REF];                          // [RQ3]
    assign dac_code       = st_ff.sar;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_rc_go;
        st_ff.state == adcs_pkg::ADCS_ACQ && reg_wr && reg_addr == `ADCS_OFF_CTRL &&
        reg_wdata[`ADCS_BIT_GO] && reg_wdata[`ADCS_BIT_ENABLE] && is_rc(st_ff.clkcfg);
    endsequence

    sequence s_quiet4;
        (!reg_wr)[*4];
    endsequence

    a_go_needs_enable: assert property (                                            // [RQ26]
        !st_ff.ctrl[`ADCS_BIT_ENABLE] |-> !st_ff.ctrl[`ADCS_BIT_GO])
        else $error("go set while converter disabled");

    a_complete_flags: assert property (                                             // [RQ22]
        $rose(st_ff.state == adcs_pkg::ADCS_HOLD) && $past(st_ff.ctrl[`ADCS_BIT_GO])
        && st_ff.ctrl[`ADCS_BIT_GO] == 1'b0 && $changed(st_ff.result) |-> st_ff.done)
        else $error("completion did not set done flag");

    a_abort_result: assert property (                                               // [RQ23]
        st_ff.state == adcs_pkg::ADCS_CONV && reg_wr && reg_addr == `ADCS_OFF_CTRL
        && !reg_wdata[`ADCS_BIT_GO] |=> $stable(st_ff.result)
        && st_ff.state == adcs_pkg::ADCS_HOLD)
        else $error("abort changed result or missed hold");

    a_clkcfg_zero: assert property (                                                // [RQ9]
        reg_rd && reg_addr == `ADCS_OFF_CLKCFG |=> reg_rdata[7] == 1'b0
        && reg_rdata[3:0] == 4'h0 && reg_rdata[6:4] == $past(st_ff.clkcfg))
        else $error("clock register readback wrong");

    a_rc_delay: assert property (                                                   // [RQ17]
        s_rc_go ##1 s_quiet4 |=> st_ff.state == adcs_pkg::ADCS_CONV
        && $past(st_ff.state, 4) == adcs_pkg::ADCS_START_DLY)
        else $error("RC start delay not one instruction cycle");

    a_sleep_abort: assert property (                                                // [RQ21]
        st_ff.state == adcs_pkg::ADCS_CONV && sleep_active && !is_rc(st_ff.clkcfg)
        |=> st_ff.state == adcs_pkg::ADCS_HOLD && !adc_power_on
        && $stable(st_ff.result))
        else $error("non-RC sleep did not abort and power down");

    a_power_off: assert property (                                                  // [RQ6]
        !st_ff.ctrl[`ADCS_BIT_ENABLE] |-> !adc_power_on)
        else $error("converter powered while disabled");

    a_right_high: assert property (                                                 // [RQ25]
        reg_rd && reg_addr == `ADCS_OFF_RES_HI && st_ff.ctrl[`ADCS_BIT_JUSTIFY]
        |=> reg_rdata == {6'h00, $past(st_ff.result[9:8])})
        else $error("right-justified high byte wrong");

    a_wake_vector: assert property (                                                // [RQ19]
        wake_vector |-> wake_req && $past(global_irq_enable))
        else $error("vector without wake or global enable");

endmodule

// ### hw/adcs_defines.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADCS_OFF_CTRL      8'h1F
`define ADCS_OFF_CLKCFG    8'h9F
`define ADCS_OFF_RES_HI    8'h1E
`define ADCS_OFF_RES_LO    8'h9E
`define ADCS_OFF_STATUS    8'h0C
`define ADCS_OFF_IRQ_EN    8'h8C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCS_BIT_JUSTIFY   7
`define ADCS_BIT_NEG_REF   6
`define ADCS_BIT_POS_REF   5
`define ADCS_CHS_HI        4
`define ADCS_CHS_LO        2
`define ADCS_BIT_GO        1
`define ADCS_BIT_ENABLE    0
`define ADCS_CKS_HI        6
`define ADCS_CKS_LO        4
`define ADCS_BIT_DONE      6
`define ADCS_BIT_IRQ_EN    6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ADCS_RST_CTRL      8'h00
`define ADCS_RST_CLKCFG    3'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ADCS_CLK_PERIOD_NS 5
`define ADCS_FRC_PERIOD_NS 2000
`define ADCS_FRC_CYCLES    ((`ADCS_FRC_PERIOD_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS)
`define ADCS_INSTR_CYCLES  4
`define ADCS_CONV_TADS     11
`define ADCS_HOLD_TADS     2

`endif

// ### hw/adcs_pkg.sv
// Types shared by the converter control modules
package adcs_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCS_ACQ       = 2'b00,
        ADCS_START_DLY = 2'b01,
        ADCS_CONV      = 2'b10,
        ADCS_HOLD      = 2'b11
    } adcs_state_t;

endpackage

// ### hw/adcs_tad_gen.sv
// Conversion bit period tick generator
`timescale 1ns/10ps
`include "adcs_defines.svh"

module adcs_tad_gen #(
    parameter int FRC_CYCLES = `ADCS_FRC_CYCLES,
    parameter int CW         = 9
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    // Control
    input  wire logic          run,
    input  wire logic [2:0]    clk_sel,
    // Tick
    output logic               tad_tick
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (FRC_CYCLES < 64 || FRC_CYCLES > (1 << CW))
        $error("adcs_tad_gen: FRC_CYCLES out of range for counter width");

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } adcs_tad_st_t;

    adcs_tad_st_t st_ff;
    adcs_tad_st_t nxt_st;

    // Last divider count, one less than the clocks per bit period, for each selection
    function automatic logic [CW-1:0] div_last(input logic [2:0] sel);
        case (sel)
            3'b000:  div_last = CW'(1);
            3'b100:  div_last = CW'(3);
            3'b001:  div_last = CW'(7);
            3'b101:  div_last = CW'(15);
            3'b010:  div_last = CW'(31);
            3'b110:  div_last = CW'(63);
            default: div_last = CW'(FRC_CYCLES - 1);                  // [RQ8]
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!run) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= div_last(clk_sel)) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tad_tick = st_ff.tick;

endmodule

// ### sim/adcs_ctrl_tb_top.sv
// Self-checking testbench for the converter control sequencer
`timescale 1ns/10ps
module adcs_ctrl_tb_top;
    logic       clk_sys, rst_b, reg_wr, reg_rd, sleep_active, global_irq_enable;
    logic       peripheral_irq_enable, cmp_in, conv_irq, wake_req, wake_vector;
    logic       adc_power_on, sample_connect, neg_ref_ext, pos_ref_ext;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] channel_sel;
    logic [9:0] dac_code;
    int         errors, num_checks, cyc;

    adcs_ctrl #(.FRC_CYCLES(64)) adcs_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_active(sleep_active),
        .global_irq_enable(global_irq_enable), .peripheral_irq_enable(peripheral_irq_enable),
        .conv_irq(conv_irq), .wake_req(wake_req), .wake_vector(wake_vector), .cmp_in(cmp_in),
        .adc_power_on(adc_power_on), .sample_connect(sample_connect),
        .channel_sel(channel_sel), .neg_ref_ext(neg_ref_ext), .pos_ref_ext(pos_ref_ext),
        .dac_code(dac_code));

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(n, {2'h0, e}, {2'h0, d});
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 1500 && s !== v; i++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [2:0] c;
        rchk("ctrl reset", 8'h1F, 8'h00);
        rchk("clkcfg reset", 8'h9F, 8'h00);
        chk("acq at reset", 1, sample_connect);
        wr(8'h9F, 8'hFF);
        rchk("clkcfg unimpl", 8'h9F, 8'h70);
        rchk("unmapped", 8'h55, 8'h00);
        wr(8'h1F, 8'h02);
        rchk("go while off", 8'h1F, 8'h00);
        chk("power off", 0, adc_power_on);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(8'h1F, {1'b0, c[0], c[1], c, 2'h0});
            chk("neg ref", {9'h0, c[0]}, {9'h0, neg_ref_ext});
            chk("pos ref", {9'h0, c[1]}, {9'h0, pos_ref_ext});
            chk("channel", {7'h0, c}, {7'h0, channel_sel});
        end
        $display("done t_regs");
    endtask
    task automatic t_conv();
        @(posedge clk_sys) cmp_in <= 1'b1;
        wr(8'h8C, 8'h40);
        wr(8'h0C, 8'h00);
        wr(8'h9F, 8'h40);
        wr(8'h1F, 8'h81);
        chk("power on", 1, adc_power_on);
        repeat (4) @(posedge clk_sys);
        wr(8'h1F, 8'h83);
        rchk("go running", 8'h1F, 8'h83);
        wait_sig(sample_connect, 1'b1);
        rchk("go cleared", 8'h1F, 8'h81);
        rchk("done flag", 8'h0C, 8'h40);
        chk("irq", 1, conv_irq);
        rchk("right hi", 8'h1E, 8'h03);
        rchk("right lo", 8'h9E, 8'hFF);
        wr(8'h1F, 8'h01);
        rchk("left hi", 8'h1E, 8'hFF);
        rchk("left lo", 8'h9E, 8'hC0);
        wr(8'h0C, 8'h00);
        chk("irq clear", 0, conv_irq);
        $display("done t_conv");
    endtask
    task automatic t_clk();
        logic [2:0] sel [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        int         per [8] = '{2, 4, 8, 16, 32, 64, 64, 64};
        int         n;
        for (int i = 0; i < 8; i++) begin
            wr(8'h9F, {1'b0, sel[i], 4'h0});
            wr(8'h1F, 8'h83);
            #1 n = 0;
            for (; n < 2000 && sample_connect !== 1'b1; n++) begin
                @(posedge clk_sys);
                #1;
            end
            chk("busy span", 1, (n >= 13 * per[i] - 2 && n <= 13 * per[i] + 6));
        end
        $display("done t_clk");
    endtask
    task automatic t_abort();
        @(posedge clk_sys) cmp_in <= 1'b0;
        wr(8'h9F, 8'h40);
        wr(8'h1F, 8'h83);
        repeat (10) @(posedge clk_sys);
        wr(8'h1F, 8'h81);
        #1 chk("hold after abort", 0, sample_connect);
        repeat (7) @(posedge clk_sys);
        #1 chk("abort hold", 0, sample_connect);
        repeat (5) @(posedge clk_sys);
        #1 chk("reacquire", 1, sample_connect);
        rchk("abort go", 8'h1F, 8'h81);
        rchk("kept hi", 8'h1E, 8'h03);
        rchk("kept lo", 8'h9E, 8'hFF);
        $display("done t_abort");
    endtask
    task automatic t_sleep();
        wr(8'h1F, 8'h83);
        repeat (5) @(posedge clk_sys);
        sleep_active <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("sleep off", 0, adc_power_on);
        rchk("sleep abort", 8'h1F, 8'h81);
        @(posedge clk_sys) sleep_active <= 1'b0;
        wr(8'h9F, 8'h30);
        wr(8'h1F, 8'h83);
        @(posedge clk_sys) sleep_active <= 1'b1;
        wait_sig(wake_req, 1'b1);
        chk("wake", 1, wake_req);
        chk("vector", 1, wake_vector);
        @(posedge clk_sys) sleep_active <= 1'b0;
        rchk("rc go", 8'h1F, 8'h81);
        rchk("rc result", 8'h9E, 8'h00);
        wr(8'h8C, 8'h00);
        wr(8'h1F, 8'h83);
        @(posedge clk_sys) sleep_active <= 1'b1;
        wait_sig(adc_power_on, 1'b0);
        chk("rc power down", 0, adc_power_on);
        rchk("enable kept", 8'h1F, 8'h81);
        @(posedge clk_sys) sleep_active <= 1'b0;
        $display("done t_sleep");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        {rst_b, reg_wr, reg_rd, sleep_active, cmp_in, reg_addr, reg_wdata} = '0;
        global_irq_enable = 1'b1;
        peripheral_irq_enable = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_conv();
        t_clk();
        t_abort();
        t_sleep();
        conclude();
    end
endmodule
